/* hw/urx_defs.svh */
// Register map, field positions, reset values and sample counts
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH
`define URX_OFF_DATA   8'h00
`define URX_OFF_STATA  8'h04
`define URX_OFF_CTRLB  8'h08
`define URX_OFF_CTRLC  8'h0c
`define URX_OFF_DIV    8'h10
`define URX_A_RXC      7
`define URX_A_FE       4
`define URX_A_DOR      3
`define URX_A_UPE      2
`define URX_A_U2X      1
`define URX_B_IE       7
`define URX_B_ON       4
`define URX_B_NINTH    1
`define URX_C_SYNC     6
`define URX_C_PEN      5
`define URX_C_ODD      4
`define URX_C_STOP2    3
`define URX_C_SIZE_LO  0
`define URX_SIZE_RST   3'h3
`define URX_SIZE_NINE  3'h7
`define URX_DIV_RST    12'h000
`define URX_SPB_NORM   5'h10
`define URX_SPB_DBL    5'h08
`define URX_VOTE_NORM  5'h08
`define URX_VOTE_DBL   5'h04
`define URX_RESP_OKAY  2'h0
`define URX_RESP_SLV   2'h2
`endif

/* hw/urx_pkg.sv */
// Types shared by the receive path
`include "urx_defs.svh"
package urx_pkg;
  typedef enum logic [2:0] {
    URX_IDLE  = 3'b001,
    URX_START = 3'b010,
    URX_FRAME = 3'b100
  } urx_state_type;
endpackage

/* hw/urx_receive_path.sv */
// Serial receive path with two-entry buffer and AXI4-Lite registers
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "urx_defs.svh"

// Overview of operation
// R1: Shift bits after valid start until stop
// R2: Only the first stop bit is examined
// R3: Completed frame moves into receive buffer
// R4: Unused upper data bits read zero
// R5: Software reads ninth bit before data
// R6: Ninth bit and errors stored per entry
// R7: Done flag set while buffer holds data
// R8: Receiver off empties buffer, clears flag
// R9: Interrupt while enabled, flag and global
// R10: Handler must read data to clear
// R11: Error flags ignore software writes
// R12: Error flags never raise interrupts
// R13: Software writes zero to error bits
// R14: Frame error reflects first stop bit
// R15: Frame error ignores stop bit count
// R16: Overrun on start with full buffer and a character waiting
// R17: Overrun clears when character moves in
// R18: Parity error zero when checking off
// R19: Parity checked against received bit
// R20: Parity error only if enabled then
// R21: Disable drops frame and releases pin
// R22: Software flushes by reading until empty
// R23: Enable hands serial pin to receiver
// R24: Oversample sixteen or eight per bit
// R25: Start needs two of three low; sync mode needs one low sample at the clock rise
// R26: Each bit decided by majority vote; sync mode takes one sample per clock rise
// R27: Odd select zero even, one odd
// R28: Buffer is two entry first in first out
module urx_receive_path (
  // Clock, reset, enable
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  // Serial pins
  input  wire logic        serial_rx_in,
  input  wire logic        ext_serial_clock_in,
  output logic             rx_pin_owned_out,
  // Interrupt
  input  wire logic        global_irq_enable_in,
  output logic             receive_done_irq_out,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in
);
  import urx_pkg::*;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic [3:0] char_bits(input logic [2:0] sz);
    if (sz == `URX_SIZE_NINE) begin
      char_bits = 4'h9;
    end else begin
      char_bits = 4'h5 + {2'h0, sz[1:0]};
    end
  endfunction

  function automatic logic [7:0] size_mask(input logic [2:0] sz);
    size_mask = 8'hff >> (4'h8 - (char_bits(sz) > 4'h8 ? 4'h8
                                                       : char_bits(sz)));
  endfunction

  // Configuration registers
  logic          ie_q;
  logic          on_q;
  logic          u2x_q;
  logic          sync_q;
  logic          pen_q;
  logic          odd_q;
  logic          stop2_q;
  logic [2:0]    size_q;
  logic [11:0]   div_reg_q;
  // Pin synchronisers
  logic          rxd_m_q;
  logic          rxd_s_q;
  logic          xck_m_q;
  logic          xck_s_q;
  logic          xck_p_q;
  // Receiver state
  urx_state_type state_q;
  logic [11:0]   div_cnt_q;
  logic [4:0]    scnt_q;
  logic [1:0]    vote_q;
  logic          rx_prev_q;
  logic [3:0]    bidx_q;
  logic [3:0]    nd_q;
  logic          fpen_q;
  logic          fodd_q;
  logic          fpar_q;
  logic [8:0]    shift_q;
  logic          perr_q;
  logic          pend_q;
  logic [11:0]   pend_ent_q;
  logic          dor_lost_q;
  // Buffer: {dor, upe, fe, data[8:0]}
  logic [11:0]   mem_q [0:1];
  logic          wp_q;
  logic          rp_q;
  logic [1:0]    cnt_q;
  // Bus state
  logic          aw_have_q;
  logic          w_have_q;
  logic [7:0]    awaddr_q;
  logic [7:0]    wdata_q;
  logic          wstrb0_q;
  logic [3:0]    wdata_hi_q;
  logic          irq_q;

  logic          tick;
  logic          xck_rise;
  logic [4:0]    spb;
  logic [4:0]    vote_first;
  logic [4:0]    vote_last;
  logic          dec;
  logic          val;
  logic          start_ok;
  logic          bit_dec;
  logic          complete;
  logic          full;
  logic [11:0]   new_ent;
  logic          push;
  logic [11:0]   push_ent;
  logic          pop;
  logic          wr_go;
  logic          rd_go;
  logic [11:0]   head;
  logic [31:0]   rd_val;
  logic          rd_ok;

  assign tick       = (div_cnt_q == 12'h000);
  assign xck_rise   = xck_s_q & ~xck_p_q;
  // Double speed halves the bit and the vote window start; the window stays three samples
  assign spb        = u2x_q ? `URX_SPB_DBL : `URX_SPB_NORM; // R24
  assign vote_first = u2x_q ? `URX_VOTE_DBL : `URX_VOTE_NORM;
  assign vote_last  = vote_first + 5'h02;
  assign full       = (cnt_q == 2'h2);
  assign head       = mem_q[rp_q];

  always_comb begin
    if (sync_q) begin
      dec = xck_rise;
      val = rxd_s_q;
    end else begin
      dec = tick & (scnt_q == vote_last);
      val = maj3({vote_q, rxd_s_q}); // R26
    end
  end

  // Start accepted: async needs a low majority, sync a low edge sample
  assign start_ok = on_q & (sync_q
      ? (state_q == URX_IDLE) & xck_rise & ~rxd_s_q
      : (state_q == URX_START) & dec & ~val); // R25
  assign bit_dec  = on_q & (state_q == URX_FRAME) & dec;
  // Stop index stops at the first stop bit; a second one is never read
  assign complete = bit_dec &
                    (bidx_q == nd_q + {3'h0, fpen_q}); // R2 R15
  assign new_ent  = {1'b0,
                     fpen_q & (perr_q ^ fpar_q ^ fodd_q), // R19 R20 R27
                     ~val, // R14
                     shift_q};
  assign push     = on_q & ((complete & ~full) | (pend_q & ~full));
  assign push_ent = complete ? new_ent : pend_ent_q;

  // Pins
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
      xck_m_q <= 1'b0;
      xck_s_q <= 1'b0;
      xck_p_q <= 1'b0;
    end else if (clk_en_in) begin
      rxd_m_q <= serial_rx_in;
      rxd_s_q <= rxd_m_q;
      xck_m_q <= ext_serial_clock_in;
      xck_s_q <= xck_m_q;
      xck_p_q <= xck_s_q;
    end
  end

  // Sample tick divider
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      div_cnt_q <= `URX_DIV_RST;
    end else if (clk_en_in) begin
      if (tick | ~on_q) begin
        div_cnt_q <= div_reg_q;
      end else begin
        div_cnt_q <= div_cnt_q - 12'h001;
      end
    end
  end

  // Frame sequencer; disable aborts at once
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q   <= URX_IDLE;
      scnt_q    <= 5'h00;
      vote_q    <= 2'h3;
      rx_prev_q <= 1'b1;
      bidx_q    <= 4'h0;
      nd_q      <= 4'h8;
      fpen_q    <= 1'b0;
      fodd_q    <= 1'b0;
      fpar_q    <= 1'b0;
      shift_q   <= 9'h000;
      perr_q    <= 1'b0;
    end else if (clk_en_in) begin
      if (~on_q) begin
        state_q   <= URX_IDLE; // R21
        rx_prev_q <= 1'b1;
      end else begin
        if (tick) begin
          rx_prev_q <= rxd_s_q;
          if (scnt_q >= vote_first && scnt_q < vote_last) begin
            vote_q <= {vote_q[0], rxd_s_q};
          end
          scnt_q <= (scnt_q == spb) ? 5'h01 : scnt_q + 5'h01;
        end
        case (state_q)
          URX_IDLE: begin
            if (start_ok) begin
              state_q <= URX_FRAME;
            end else if (~sync_q & tick & rx_prev_q & ~rxd_s_q) begin
              state_q <= URX_START;
              scnt_q  <= 5'h02;
            end
          end
          URX_START: begin
            if (dec) begin
              state_q <= val ? URX_IDLE : URX_FRAME;
            end
          end
          URX_FRAME: begin
            if (bit_dec) begin
              bidx_q <= bidx_q + 4'h1; // R1
              if (bidx_q < nd_q) begin
                shift_q[bidx_q] <= val;
                perr_q          <= perr_q ^ val;
              end else if (fpen_q && bidx_q == nd_q) begin
                fpar_q <= val;
              end
              if (complete) begin
                state_q <= URX_IDLE; // R3
                rx_prev_q <= val;
              end
            end
          end
          default: state_q <= URX_IDLE;
        endcase
        // Frame format is frozen at the start bit
        if (start_ok) begin
          bidx_q  <= 4'h0;
          nd_q    <= char_bits(size_q);
          fpen_q  <= pen_q;
          fodd_q  <= odd_q;
          fpar_q  <= 1'b0;
          shift_q <= 9'h000; // R4
          perr_q  <= 1'b0;
        end
      end
    end
  end

  // Waiting character and overrun
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pend_q     <= 1'b0;
      pend_ent_q <= 12'h000;
      dor_lost_q <= 1'b0;
    end else if (clk_en_in) begin
      if (~on_q) begin
        pend_q     <= 1'b0;
        dor_lost_q <= 1'b0;
      end else if (start_ok & pend_q & full) begin
        // New frame overwrites the waiting one
        pend_q     <= 1'b0;
        dor_lost_q <= 1'b1; // R16
      end else if (complete & full) begin
        pend_q     <= 1'b1;
        pend_ent_q <= new_ent;
      end else if (push) begin
        pend_q     <= 1'b0;
        dor_lost_q <= 1'b0; // R17
      end
    end
  end

  // Two-entry buffer
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mem_q[0] <= 12'h000;
      mem_q[1] <= 12'h000;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else if (clk_en_in) begin
      if (~on_q) begin
        cnt_q <= 2'h0; // R8 R21
        wp_q  <= 1'b0;
        rp_q  <= 1'b0;
      end else begin
        if (push) begin
          mem_q[wp_q] <= {dor_lost_q, push_ent[10:0]}; // R6
          wp_q        <= ~wp_q;
        end
        if (pop) begin
          rp_q <= ~rp_q; // R28
        end
        cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
    end
  end

  // Interrupt is a registered level of the done flag
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_q <= 1'b0;
    end else if (clk_en_in) begin
      irq_q <= ie_q & (cnt_q != 2'h0) & global_irq_enable_in; // R9 R12
    end
  end

  // Write channel
  assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid_out;
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      aw_have_q         <= 1'b0;
      w_have_q          <= 1'b0;
      awaddr_q          <= 8'h00;
      wdata_q           <= 8'h00;
      wstrb0_q          <= 1'b0;
      wdata_hi_q        <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `URX_RESP_OKAY;
    end else if (clk_en_in) begin
      if (s_axi_awvalid_in & s_axi_awready_out) begin
        aw_have_q         <= 1'b1;
        awaddr_q          <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in & s_axi_wready_out) begin
        w_have_q         <= 1'b1;
        wdata_q          <= s_axi_wdata_in[7:0];
        wstrb0_q         <= s_axi_wstrb_in[0];
        wdata_hi_q       <= s_axi_wdata_in[11:8];
        s_axi_wready_out <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q        <= 1'b0;
        w_have_q         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        case (awaddr_q)
          `URX_OFF_DATA, `URX_OFF_STATA, `URX_OFF_CTRLB,
          `URX_OFF_CTRLC, `URX_OFF_DIV:
            s_axi_bresp_out <= `URX_RESP_OKAY;
          default: s_axi_bresp_out <= `URX_RESP_SLV;
        endcase
      end
      if (s_axi_bvalid_out & s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // Control registers; error flag positions are not writable
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ie_q      <= 1'b0;
      on_q      <= 1'b0;
      u2x_q     <= 1'b0;
      sync_q    <= 1'b0;
      pen_q     <= 1'b0;
      odd_q     <= 1'b0;
      stop2_q   <= 1'b0;
      size_q    <= `URX_SIZE_RST;
      div_reg_q <= `URX_DIV_RST;
    end else if (clk_en_in) begin
      if (wr_go & wstrb0_q) begin
        case (awaddr_q)
          `URX_OFF_STATA: u2x_q <= wdata_q[`URX_A_U2X]; // R11
          `URX_OFF_CTRLB: begin
            ie_q <= wdata_q[`URX_B_IE];
            on_q <= wdata_q[`URX_B_ON]; // R23
          end
          `URX_OFF_CTRLC: begin
            sync_q  <= wdata_q[`URX_C_SYNC];
            pen_q   <= wdata_q[`URX_C_PEN];
            odd_q   <= wdata_q[`URX_C_ODD];
            stop2_q <= wdata_q[`URX_C_STOP2];
            size_q  <= wdata_q[`URX_C_SIZE_LO +: 3];
          end
          `URX_OFF_DIV: div_reg_q <= {wdata_hi_q, wdata_q};
          default: ;
        endcase
      end
    end
  end

  // Read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr_in)
      `URX_OFF_DATA: rd_val[7:0] = head[7:0] & size_mask(size_q); // R4
      `URX_OFF_STATA: begin
        rd_val[`URX_A_RXC] = (cnt_q != 2'h0); // R7
        rd_val[`URX_A_FE]  = (cnt_q != 2'h0) & head[9];
        rd_val[`URX_A_DOR] = (cnt_q != 2'h0) & head[11];
        rd_val[`URX_A_UPE] = (cnt_q != 2'h0) & head[10]; // R18
        rd_val[`URX_A_U2X] = u2x_q;
      end
      `URX_OFF_CTRLB: begin
        rd_val[`URX_B_IE]    = ie_q;
        rd_val[`URX_B_ON]    = on_q;
        rd_val[`URX_B_NINTH] = (cnt_q != 2'h0) & head[8]; // R6
      end
      `URX_OFF_CTRLC: begin
        rd_val[`URX_C_SYNC]  = sync_q;
        rd_val[`URX_C_PEN]   = pen_q;
        rd_val[`URX_C_ODD]   = odd_q;
        rd_val[`URX_C_STOP2] = stop2_q;
        rd_val[`URX_C_SIZE_LO +: 3] = size_q;
      end
      `URX_OFF_DIV: rd_val[11:0] = div_reg_q;
      default: rd_ok = 1'b0;
    endcase
  end

  assign rd_go = s_axi_arvalid_in & s_axi_arready_out;
  // Reading data pops the head, so status must be read first
  assign pop   = rd_go & (s_axi_araddr_in == `URX_OFF_DATA) &
                 (cnt_q != 2'h0) & on_q;

  // Read channel
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `URX_RESP_OKAY;
    end else if (clk_en_in) begin
      if (rd_go) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= rd_val;
        s_axi_rresp_out   <= rd_ok ? `URX_RESP_OKAY : `URX_RESP_SLV;
      end else if (s_axi_rvalid_out & s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // Pin ownership follows the enable
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rx_pin_owned_out <= 1'b0;
    end else if (clk_en_in) begin
      rx_pin_owned_out <= on_q; // R23 R21
    end
  end

  assign receive_done_irq_out = irq_q;

endmodule

/* bench/urx_receive_path_sva.sv */
// Receive path bus, interrupt and pin checks
`timescale 1ns/1ps
`include "urx_defs.svh"
module urx_receive_path_sva (
  // Clock, reset, interrupt and pin
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        global_irq_enable_in,
  input wire logic        receive_done_irq_out,
  input wire logic        rx_pin_owned_out,
  // Register bus
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic [7:0]  s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // Cycles since the last bus request
  logic [2:0] since_q;
  logic       unmap_q;
  logic       data_q;
  always_ff @(posedge mclk_in) begin
    if (reset_in)
      since_q <= 3'h7;
    else if ((s_axi_awvalid_in && s_axi_awready_out) ||
             (s_axi_arvalid_in && s_axi_arready_out))
      since_q <= 3'h0;
    else if (since_q != 3'h7)
      since_q <= since_q + 3'h1;
  end
  always_ff @(posedge mclk_in) begin
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      unmap_q <= !(s_axi_araddr_in inside {`URX_OFF_DATA, `URX_OFF_STATA,
                   `URX_OFF_CTRLB, `URX_OFF_CTRLC, `URX_OFF_DIV});
      data_q  <= s_axi_araddr_in == `URX_OFF_DATA;
    end
  end
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  chk_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid_out)
    else $error("write response not on time");
  chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid_out)
    else $error("read data not on time");
  chk_b_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  chk_r_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  chk_aw_refused: assert property (s_axi_bvalid_out |->
    !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while response pending");
  chk_unmapped_err: assert property (s_axi_rvalid_out && unmap_q |->
    s_axi_rresp_out == `URX_RESP_SLV && s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
  chk_data_upper: assert property (s_axi_rvalid_out && data_q |->
    s_axi_rdata_out[31:8] == 24'h0)
    else $error("data upper bits not zero");
  chk_irq_global: assert property (!global_irq_enable_in |=>
    !receive_done_irq_out)
    else $error("interrupt without global enable");
  chk_irq_holds: assert property (receive_done_irq_out &&
    global_irq_enable_in && since_q == 3'h7 |=> receive_done_irq_out)
    else $error("interrupt dropped without a read");
  chk_pin_follows: assert property ($changed(rx_pin_owned_out) |->
    since_q <= 3'h4)
    else $error("pin ownership changed without a write");
endmodule

bind urx_receive_path urx_receive_path_sva i_sva (
  .mclk_in(mclk_in), .reset_in(reset_in),
  .global_irq_enable_in(global_irq_enable_in),
  .receive_done_irq_out(receive_done_irq_out),
  .rx_pin_owned_out(rx_pin_owned_out),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in));

/* bench/urx_remote_tx.sv */
// Remote transmitter model that drives the serial line
`timescale 1ns/1ps
module urx_remote_tx (
  // Clock and frame request
  input  wire logic        mclk_in,
  input  wire logic        go_in,
  input  wire logic [13:0] bits_in,
  input  wire logic [3:0]  count_in,
  input  wire logic [4:0]  len_in,
  // Line side
  output logic             line_out,
  output logic             busy_out
);
  logic [13:0] sh_q;
  logic [3:0]  left_q;
  logic [4:0]  cyc_q;
  // Line idles high like a pulled-up pin
  initial begin
    line_out = 1'b1;
    busy_out = 1'b0;
  end
  always @(posedge mclk_in) begin
    if (go_in && !busy_out) begin
      line_out <= bits_in[0];
      sh_q     <= bits_in >> 1;
      left_q   <= count_in - 4'h1;
      cyc_q    <= len_in - 5'h1;
      busy_out <= 1'b1;
    end else if (busy_out && cyc_q != 5'h0) begin
      cyc_q <= cyc_q - 5'h1;
    end else if (busy_out && left_q == 4'h0) begin
      line_out <= 1'b1;
      busy_out <= 1'b0;
    end else if (busy_out) begin
      line_out <= sh_q[0];
      sh_q     <= sh_q >> 1;
      left_q   <= left_q - 4'h1;
      cyc_q    <= len_in - 5'h1;
    end
  end
endmodule

/* bench/testbench.sv */
// Randomised self-checking bench for the receive path
`timescale 1ns/1ps
`include "urx_defs.svh"
module testbench;
  logic        mclk_in, reset_in, gie, go, busy, line, own, irq;
  logic        awv, awr, wv, wrdy, bv, bry, arv, arr, rv, rry;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws, fcnt;
  logic [1:0]  bresp, rresp;
  logic [13:0] fbits;
  logic [4:0]  flen;
  int          miscompares, checks;

  urx_receive_path i_dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(1'b1),
    .serial_rx_in(line), .ext_serial_clock_in(1'b0),
    .rx_pin_owned_out(own), .global_irq_enable_in(gie),
    .receive_done_irq_out(irq),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rry));
  urx_remote_tx i_tx (.mclk_in(mclk_in), .go_in(go), .bits_in(fbits),
    .count_in(fcnt), .len_in(flen), .line_out(line), .busy_out(busy));

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    $display("mismatch at %0t: wait ran out", $time);
    final_report;
  endtask
  task automatic cmp(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_in);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    @(posedge mclk_in);
    if (n == 50) hang;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_in);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdat;
    r = rresp;
    rry <= 1'b0;
    @(posedge mclk_in);
    if (n == 50) hang;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    cmp(d, e, "register read");
  endtask
  task automatic launch(input logic [13:0] b, input logic [3:0] c,
                        input logic [4:0] l);
    fbits <= b;
    fcnt  <= c;
    flen  <= l;
    go    <= 1'b1;
    @(posedge mclk_in);
    go <= 1'b0;
  endtask
  task automatic txwait;
    int n;
    for (n = 0; n < 600; n++) begin
      @(posedge mclk_in);
      if (!busy) break;
    end
    if (n == 600) hang;
  endtask
  // Start, data, parity, first stop, idle second stop
  task automatic send(input logic [8:0] d, input int sz,
                      input logic pen, odd, bad, stp, input logic [4:0] l);
    logic [13:0] b;
    logic        p;
    int          i;
    b = 14'h3fff;
    b[0] = 1'b0;
    p = odd ^ bad;
    for (i = 0; i < sz; i++) begin
      b[i + 1] = d[i];
      p = p ^ d[i];
    end
    i = sz + 1;
    if (pen) begin
      b[i] = p;
      i++;
    end
    b[i] = stp;
    launch(b, 4'(i + 2), l);
    txwait;
  endtask
  function automatic logic [31:0] st(input logic fe, ov, pe, dbl);
    return {24'h0, 1'b1, 2'b0, fe, ov, pe, dbl, 1'b0};
  endfunction
  function automatic logic [31:0] msk(input logic [8:0] d, input int sz);
    return {24'h0, d[7:0] & (8'hff >> (sz > 8 ? 0 : 8 - sz))};
  endfunction

  initial begin
    repeat (100000) @(posedge mclk_in);
    hang;
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [8:0]  v [4];
    logic [1:0]  f [2];
    logic        pen, odd, dbl, ie;
    int          k, j, sz;
    {reset_in, awv, wv, bry, arv, rry, go} = 7'h40;
    {gie, awa, ara, wd, fbits, fcnt, flen} = '0;
    ws = 4'hf;
    miscompares = 0;
    checks = 0;
    k = $urandom(32'h7cd4);
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    chk(`URX_OFF_STATA, 32'h0);
    chk(`URX_OFF_CTRLB, 32'h0);
    chk(`URX_OFF_CTRLC, 32'h3);
    chk(`URX_OFF_DIV, 32'h0);
    rd(8'h20, d, r);
    cmp(r, `URX_RESP_SLV, "unmapped response");
    cmp(d, 32'h0, "unmapped data");
    // Masked lane leaves format
    ws <= 4'h0;
    wr(`URX_OFF_CTRLC, 32'h0);
    ws <= 4'hf;
    chk(`URX_OFF_CTRLC, 32'h3);
    for (k = 0; k < 10; k++) begin
      sz = (k % 5 == 4) ? 9 : 5 + k % 5;
      {pen, odd, dbl, ie} = 4'($urandom);
      gie <= 1'($urandom);
      wr(`URX_OFF_CTRLC, {pen, odd, 1'($urandom), 3'(sz == 9 ? 7 : sz - 5)});
      wr(`URX_OFF_STATA, {dbl, 1'b0});
      wr(`URX_OFF_CTRLB, {ie, 7'h10});
      for (j = 0; j < 2; j++) begin
        v[j] = 9'($urandom);
        f[j] = 2'($urandom);
        send(v[j], sz, pen, odd, f[j][0], f[j][1], dbl ? 5'h08 : 5'h10);
      end
      cmp(irq, ie & gie, "interrupt");
      wr(`URX_OFF_STATA, {3'h7, dbl, 1'b0});
      for (j = 0; j < 2; j++) begin
        chk(`URX_OFF_STATA, st(~f[j][1], 0, pen & f[j][0], dbl));
        chk(`URX_OFF_CTRLB, {ie, 5'h04, sz == 9 && v[j][8], 1'b0});
        chk(`URX_OFF_DATA, msk(v[j], sz));
      end
      chk(`URX_OFF_STATA, {dbl, 1'b0});
    end
    // Four frames, two entries: third lost
    wr(`URX_OFF_CTRLC, 32'h3);
    wr(`URX_OFF_STATA, 32'h0);
    wr(`URX_OFF_CTRLB, 32'h10);
    for (j = 0; j < 4; j++) begin
      v[j] = 9'($urandom);
      send(v[j], 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    end
    chk(`URX_OFF_DATA, msk(v[0], 8));
    chk(`URX_OFF_STATA, st(0, 0, 0, 0));
    chk(`URX_OFF_DATA, msk(v[1], 8));
    chk(`URX_OFF_STATA, st(0, 1, 0, 0));
    chk(`URX_OFF_DATA, msk(v[3], 8));
    send(v[2], 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    chk(`URX_OFF_STATA, st(0, 0, 0, 0));
    chk(`URX_OFF_DATA, msk(v[2], 8));
    // Disable mid-frame, one buffered
    send(v[0], 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    fork
      send(v[1], 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
      begin
        repeat (40) @(posedge mclk_in);
        wr(`URX_OFF_CTRLB, 32'h0);
      end
    join
    cmp(own, 1'b0, "pin owner");
    chk(`URX_OFF_STATA, 32'h0);
    wr(`URX_OFF_CTRLB, 32'h10);
    cmp(own, 1'b1, "pin owner");
    // Noise pulse
    launch(14'h0, 4'h1, 5'h04);
    txwait;
    send(v[2], 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    chk(`URX_OFF_DATA, msk(v[2], 8));
    chk(`URX_OFF_STATA, 32'h0);
    final_report;
  end
endmodule
